// [logic/sflc_pkg.sv]
// Constants, register map and helpers for the fast-lock synthesizer control.
// Assumes one 40 MHz clock and a plain synchronous register port.
//
// Operation
// (R1) Output ratio is integer plus numerator/modulus
// (R2) Comparison rate from doubler, counter, halver
// (R3) Halver gives a 50% duty comparison
// (R4) Software keeps comparison rate at most 32MHz
// (R5) Modulus is a 12-bit programmable value
// (R6) Impending slip enables one extra pump cell
// (R7) Each further threat adds a cell, seven max
// (R8) Past target, cells switch off one by one
// (R9) Slip reduction enabled by bit 28 only
// (R10) Software keeps duty 45-55% with slip reduction
// (R11) Software avoids slip reduction with negative polarity
// (R12) New load starts timer, boost, switch at once
// (R13) Wideband lasts the programmed timeout value
// (R14) Timeout end drops boost and switch
// (R15) Software times timeout near final frequency
// (R16) Reference counter divides by 1 to 32
// (R17) Mode 01 selects switching, 00 selects none
// (R18) Timeout length is a 12-bit field
// (R19) Software sets polarity zero for negative oscillator
// (R20) Timeout counts down once per comparison cycle
`default_nettype none

package sflc_pkg;
  // ----------------------------------------------------------------
  // Register port and offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [4:0] OFS_FRACTION_NUMERATOR_INT = 5'h00;
  localparam logic [4:0] OFS_MOD_CNT = 5'h08;
  localparam logic [4:0] OFS_FUNCTION = 5'h0c;
  localparam logic [4:0] OFS_CLK_DIV = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [31:0] RST_REG = 32'h0;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FRACTION_NUMERATOR_LSB = 3;
  localparam int FRACTION_NUMERATOR_W = 12;
  localparam int INT_LSB = 15;
  localparam int INT_W = 16;
  localparam int MOD_LSB = 3;
  localparam int MOD_W = 12;
  localparam int RCNT_LSB = 15;
  localparam int RCNT_W = 5;
  localparam int DBL_BIT = 20;
  localparam int HALF_BIT = 21;
  localparam int SLIP_EN_BIT = 28;
  localparam int POL_BIT = 6;
  localparam int CDV_LSB = 7;
  localparam int CDV_W = 12;
  localparam int CDM_LSB = 19;
  localparam int CDM_W = 2;
  localparam logic [1:0] CDM_NONE = 2'h0;
  localparam logic [1:0] CDM_FAST = 2'h1;
  // ----------------------------------------------------------------
  // Limits
  // ----------------------------------------------------------------
  localparam int MAX_CELLS = 7;
  localparam int PFD_MAX_MHZ = 32;

  // Thermometer code of the enabled extra pump cells
  function automatic logic [6:0] sflc_therm(input logic [2:0] n);
    logic [6:0] t;
    t = 7'h0;
    for (int i = 0; i < 7; i++) begin
      t[i] = (3'(i) < n);
    end
    return t;
  endfunction : sflc_therm
endpackage : sflc_pkg

`default_nettype wire

// [logic/sflc_refdiv.sv]
// Reference path: optional doubler, programmable counter, optional halver.
// Assumes the reference input is synchronous to the system clock.
`default_nettype none

module sflc_refdiv #(
  parameter int CNT_W = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Settings
  input wire logic ref_i,
  input wire logic dbl_i,
  input wire logic half_i,
  input wire logic [CNT_W-1:0] rdiv_i,
  // Comparison outputs
  output logic pfd_clk_o,
  output logic pfd_tick_o
);
  // Elaboration check on the counter width
  if (CNT_W < 1 || CNT_W > 8) begin : g_bad_width
    $error("sflc_refdiv: CNT_W out of range");
  end

  typedef struct packed {
    logic ref_q;
    logic [CNT_W:0] cnt;
    logic half;
    logic tick;
    logic pclk;
  } sflc_ref_t;

  sflc_ref_t st_ff, nxt_st;
  logic [CNT_W:0] ratio;
  logic ev;
  logic wrap;

  // Divider step on each selected reference edge
  always_comb begin
    nxt_st = st_ff;
    ratio = (rdiv_i == '0) ? (CNT_W+1)'(1 << CNT_W) : {1'b0, rdiv_i}; // R16
    ev = (ref_i & ~st_ff.ref_q) | (dbl_i & ~ref_i & st_ff.ref_q); // R2
    wrap = ev && (st_ff.cnt + (CNT_W+1)'(1) >= ratio);
    nxt_st.ref_q = ref_i;
    nxt_st.tick = 1'b0;
    if (ev) begin
      nxt_st.cnt = wrap ? '0 : st_ff.cnt + (CNT_W+1)'(1);
    end
    if (wrap) begin
      nxt_st.half = half_i ? ~st_ff.half : 1'b0; // R3
      nxt_st.tick = ~half_i | ~st_ff.half; // R2
    end
    nxt_st.pclk = half_i ? nxt_st.half : nxt_st.tick; // R3
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pfd_clk_o = st_ff.pclk;
  assign pfd_tick_o = st_ff.tick;

  a_half_rise: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R3
    half_i && $rose(st_ff.half) |-> st_ff.tick)
    else $error("halved tick not on rising half");
endmodule : sflc_refdiv

`default_nettype wire

// [logic/sflc_slip.sv]
// Extra charge-pump cell stager for slip reduction.
// Assumes warning and overshoot flags come from the phase detector, sync.
`default_nettype none

module sflc_slip (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Control and detector flags
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic warn_i,
  input wire logic pass_i,
  input wire logic up_i,
  // Cell drive
  output logic [2:0] cells_o,
  output logic src_o
);
  typedef struct packed {
    logic [2:0] cells;
    logic falling;
    logic src;
  } sflc_slip_t;

  sflc_slip_t st_ff, nxt_st;

  // Stage cells up on warnings, down after overshoot
  always_comb begin
    nxt_st = st_ff;
    if (!en_i) begin
      nxt_st = '0; // R9
    end else if (st_ff.falling || pass_i) begin
      nxt_st.falling = 1'b1; // R8
      if (tick_i && st_ff.cells != 3'h0) begin
        nxt_st.cells = st_ff.cells - 3'h1; // R8
      end else if (st_ff.cells == 3'h0) begin
        nxt_st.falling = 1'b0;
      end
    end else if (warn_i && 32'(st_ff.cells) < sflc_pkg::MAX_CELLS) begin
      nxt_st.cells = st_ff.cells + 3'h1; // R6 R7
      nxt_st.src = up_i; // R6
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cells_o = st_ff.cells;
  assign src_o = st_ff.src;

  a_cell_add: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R7
    en_i && warn_i && !pass_i && !st_ff.falling && st_ff.cells < 3'h7
    |=> st_ff.cells == $past(st_ff.cells) + 3'h1)
    else $error("cell not added on warning");
  a_cell_drop: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R8
    en_i && st_ff.falling && tick_i && st_ff.cells != 3'h0
    |=> st_ff.cells == $past(st_ff.cells) - 3'h1)
    else $error("cell not dropped after overshoot");
  a_cell_off: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R9
    !en_i |=> st_ff.cells == 3'h0)
    else $error("cells on while disabled");
  c_seven_cells: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    st_ff.cells == 3'h7);
endmodule : sflc_slip

`default_nettype wire

// [logic/sflc_top.sv]
// Fast-lock synthesizer control: registers, fractional ratio, timeout.
// Assumes a synchronous register port and detector flags on CLK_I.
// Assumes software keeps the comparison rate and duty within limits.
// Assumes the loop filter switch is wired to the multiplexed pin.
//
// Our own choices: the plain strobed port and the register offsets.
`default_nettype none

module sflc_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Register port
  input wire logic [sflc_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [sflc_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  output logic [sflc_pkg::DATA_W-1:0] RDATA_O,
  // Reference and detector flags
  input wire logic REF_I,
  input wire logic SLIP_WARN_I,
  input wire logic FREQ_PASSED_I,
  input wire logic TUNE_UP_I,
  // Comparison and divider
  output logic PFD_CLK_O,
  output logic PFD_TICK_O,
  output logic [sflc_pkg::INT_W:0] N_DIV_O,
  // Fast-lock drive
  output logic CP_BOOST_O,
  output logic MULTIPLEXED_OUTPUT_PIN_O,
  output logic [6:0] CELL_EN_O,
  output logic CELL_SRC_O
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] fraction_numerator_int;
    logic [31:0] mod_cnt;
    logic [31:0] func;
    logic [31:0] clk_div;
    logic [31:0] rdata;
    logic [sflc_pkg::CDV_W-1:0] tmo;
    logic wide;
    logic [sflc_pkg::MOD_W:0] acc;
    logic [sflc_pkg::INT_W:0] ndiv;
    logic [6:0] cell_en;
    logic cell_src;
  } sflc_top_t;

  sflc_top_t st_ff, nxt_st;
  logic pfd_clk;
  logic pfd_tick;
  logic [2:0] cells;
  logic cell_src;

  // Field views of the programmed registers
  logic [sflc_pkg::FRACTION_NUMERATOR_W-1:0] fraction_numerator;
  logic [sflc_pkg::INT_W-1:0] intv;
  logic [sflc_pkg::MOD_W-1:0] modv;
  logic [sflc_pkg::RCNT_W-1:0] rdiv;
  logic [sflc_pkg::CDV_W-1:0] cdv;
  logic [1:0] cdm;
  logic slip_en;
  logic [sflc_pkg::MOD_W:0] acc_sum;
  logic load_freq;

  assign fraction_numerator = st_ff.fraction_numerator_int[sflc_pkg::FRACTION_NUMERATOR_LSB +: sflc_pkg::FRACTION_NUMERATOR_W];
  assign intv = st_ff.fraction_numerator_int[sflc_pkg::INT_LSB +: sflc_pkg::INT_W];
  assign modv = st_ff.mod_cnt[sflc_pkg::MOD_LSB +: sflc_pkg::MOD_W]; // R5
  assign rdiv = st_ff.mod_cnt[sflc_pkg::RCNT_LSB +: sflc_pkg::RCNT_W];
  assign cdv = st_ff.clk_div[sflc_pkg::CDV_LSB +: sflc_pkg::CDV_W]; // R18
  assign cdm = st_ff.clk_div[sflc_pkg::CDM_LSB +: sflc_pkg::CDM_W];
  assign slip_en = st_ff.mod_cnt[sflc_pkg::SLIP_EN_BIT]; // R9
  assign acc_sum = st_ff.acc + {1'b0, fraction_numerator};
  assign load_freq = WE_I && (ADDR_I == sflc_pkg::OFS_FRACTION_NUMERATOR_INT);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Carry out of the fraction accumulator; a zero modulus never carries
  function automatic logic fraction_numerator_carry(input logic [sflc_pkg::MOD_W:0] sum,
                                      input logic [sflc_pkg::MOD_W-1:0] m);
    return (m != '0) && (sum >= {1'b0, m});
  endfunction : fraction_numerator_carry

  // ----------------------------------------------------------------
  // Reference path and slip stager
  // ----------------------------------------------------------------
  sflc_refdiv #(
    .CNT_W(sflc_pkg::RCNT_W)
  ) u_refdiv (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .ref_i(REF_I),
    .dbl_i(st_ff.mod_cnt[sflc_pkg::DBL_BIT]),
    .half_i(st_ff.mod_cnt[sflc_pkg::HALF_BIT]),
    .rdiv_i(rdiv),
    .pfd_clk_o(pfd_clk),
    .pfd_tick_o(pfd_tick)
  );

  sflc_slip u_slip (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .en_i(slip_en),
    .tick_i(pfd_tick),
    .warn_i(SLIP_WARN_I),
    .pass_i(FREQ_PASSED_I),
    .up_i(TUNE_UP_I),
    .cells_o(cells),
    .src_o(cell_src)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Register writes
    if (WE_I) begin
      unique case (ADDR_I)
        sflc_pkg::OFS_FRACTION_NUMERATOR_INT: nxt_st.fraction_numerator_int = WDATA_I;
        sflc_pkg::OFS_MOD_CNT: nxt_st.mod_cnt = WDATA_I; // R5
        sflc_pkg::OFS_FUNCTION: nxt_st.func = WDATA_I;
        sflc_pkg::OFS_CLK_DIV: nxt_st.clk_div = WDATA_I; // R17 R18
        default: nxt_st.fraction_numerator_int = st_ff.fraction_numerator_int;
      endcase
    end
    // Read data, one cycle after the strobe
    nxt_st.rdata = '0;
    if (RE_I) begin
      unique case (ADDR_I)
        sflc_pkg::OFS_FRACTION_NUMERATOR_INT: nxt_st.rdata = st_ff.fraction_numerator_int;
        sflc_pkg::OFS_MOD_CNT: nxt_st.rdata = st_ff.mod_cnt;
        sflc_pkg::OFS_FUNCTION: nxt_st.rdata = st_ff.func;
        sflc_pkg::OFS_CLK_DIV: nxt_st.rdata = st_ff.clk_div;
        sflc_pkg::OFS_STATUS: nxt_st.rdata = {9'h0, st_ff.ndiv, st_ff.tmo[2:0] == 3'h0,
                                               st_ff.wide, cell_src, cells};
        default: nxt_st.rdata = '0;
      endcase
    end
    // Fractional ratio: first-order accumulator over the modulus
    if (pfd_tick) begin
      if (fraction_numerator_carry(acc_sum, modv)) begin
        nxt_st.acc = acc_sum - {1'b0, modv}; // R1
        nxt_st.ndiv = {1'b0, intv} + (sflc_pkg::INT_W+1)'(1); // R1
      end else begin
        nxt_st.acc = (modv == '0) ? '0 : acc_sum; // R1
        nxt_st.ndiv = {1'b0, intv};
      end
    end
    // Wideband timeout, counted in comparison cycles
    if (st_ff.wide && pfd_tick) begin
      nxt_st.tmo = st_ff.tmo - sflc_pkg::CDV_W'(1); // R20
      if (st_ff.tmo == sflc_pkg::CDV_W'(1)) begin
        nxt_st.wide = 1'b0; // R14
      end
    end
    if (cdm != sflc_pkg::CDM_FAST) begin
      nxt_st.wide = 1'b0; // R17
      nxt_st.tmo = '0;
    end
    if (load_freq) begin
      nxt_st.acc = '0;
      if (cdm == sflc_pkg::CDM_FAST && cdv != '0) begin
        nxt_st.tmo = cdv; // R12 R13
        nxt_st.wide = 1'b1; // R12
      end
    end
    // Output drive
    nxt_st.cell_en = sflc_pkg::sflc_therm(cells); // R6 R7
    nxt_st.cell_src = cell_src; // R6
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs, all from flip-flops
  assign RDATA_O = st_ff.rdata;
  assign PFD_CLK_O = pfd_clk;
  assign PFD_TICK_O = pfd_tick;
  assign N_DIV_O = st_ff.ndiv;
  assign CP_BOOST_O = st_ff.wide; // R12 R14
  assign MULTIPLEXED_OUTPUT_PIN_O = st_ff.wide; // R12 R14
  assign CELL_EN_O = st_ff.cell_en;
  assign CELL_SRC_O = st_ff.cell_src;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wide_start: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R12
    load_freq && cdm == sflc_pkg::CDM_FAST && cdv != '0
    |=> CP_BOOST_O && MULTIPLEXED_OUTPUT_PIN_O && st_ff.tmo == $past(cdv))
    else $error("wideband not entered on load");
  a_wide_hold: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R13
    st_ff.wide && st_ff.tmo > 12'h1 && !pfd_tick && !WE_I |=> st_ff.wide)
    else $error("wideband left early");
  a_wide_end: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R14
    st_ff.wide && pfd_tick && st_ff.tmo == 12'h1 && !load_freq |=> !CP_BOOST_O)
    else $error("wideband not left at timeout");
  a_tmo_step: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R20
    st_ff.wide && pfd_tick && !WE_I |=> st_ff.tmo == $past(st_ff.tmo) - 12'h1)
    else $error("timeout not one per comparison");
  a_mode_none: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R17
    cdm == sflc_pkg::CDM_NONE && !WE_I |=> !st_ff.wide)
    else $error("wideband with mode 00");
  a_fraction_numerator_carry: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R1
    pfd_tick && !WE_I && fraction_numerator_carry(acc_sum, modv)
    |=> N_DIV_O == $past({1'b0, intv}) + 17'h1)
    else $error("fraction carry not applied");
  a_read_late: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    !RE_I |=> RDATA_O == 32'h0)
    else $error("read data outside its cycle");
  a_cells_therm: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R7
    ##1 CELL_EN_O == sflc_pkg::sflc_therm($past(cells)))
    else $error("cell drive mismatch");
  // Register writes land whole in the next cycle; reads return the register, or zero when unmapped
  a_write_fraction_numerator: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R1
    WE_I && ADDR_I == sflc_pkg::OFS_FRACTION_NUMERATOR_INT
    |=> st_ff.fraction_numerator_int == $past(WDATA_I))
    else $error("frequency word write lost");
  a_write_mod: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R5
    WE_I && ADDR_I == sflc_pkg::OFS_MOD_CNT
    |=> st_ff.mod_cnt == $past(WDATA_I))
    else $error("modulus register write lost");
  a_write_cdiv: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R18
    WE_I && ADDR_I == sflc_pkg::OFS_CLK_DIV
    |=> st_ff.clk_div == $past(WDATA_I))
    else $error("clock divider write lost");
  a_read_word: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R5
    RE_I && ADDR_I == sflc_pkg::OFS_MOD_CNT
    |=> RDATA_O == $past(st_ff.mod_cnt))
    else $error("modulus readback wrong");
  a_read_gap: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    RE_I && ADDR_I == 5'h04
    |=> RDATA_O == 32'h0)
    else $error("unmapped read not zero");
  // Fraction accumulator
  a_fraction_numerator_plain: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R1
    pfd_tick && !WE_I && !fraction_numerator_carry(acc_sum, modv)
    |=> N_DIV_O == $past({1'b0, intv}))
    else $error("integer divide not applied");
  a_acc_bound: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R5
    modv != '0 && st_ff.acc < {1'b0, modv} && fraction_numerator < modv && !WE_I
    |=> st_ff.acc < {1'b0, modv})
    else $error("accumulator beyond modulus");
  a_load_clear: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R1
    load_freq |=> st_ff.acc == '0)
    else $error("accumulator not cleared on load");
  a_ndiv_hold: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R1
    !pfd_tick |=> N_DIV_O == $past(N_DIV_O))
    else $error("divide value moved without tick");
  // Wideband timer
  a_wide_zero: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R13
    load_freq && cdv == '0 && !st_ff.wide
    |=> !CP_BOOST_O)
    else $error("wideband with zero timeout");
  a_tmo_live: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R13
    st_ff.wide |-> st_ff.tmo != '0)
    else $error("wideband with spent timer");
  a_mode_leave: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R17
    cdm != sflc_pkg::CDM_FAST && !WE_I
    |=> st_ff.tmo == '0)
    else $error("timer kept outside fast lock");
  a_tmo_idle: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R20
    st_ff.wide && !pfd_tick && !WE_I
    |=> st_ff.tmo == $past(st_ff.tmo))
    else $error("timer moved without tick");
  // Extra pump cells
  a_cell_src: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R6
    1'b1 |=> CELL_SRC_O == $past(cell_src))
    else $error("cell direction not driven");
  a_cells_full: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R7
    CELL_EN_O[6] |-> CELL_EN_O[5:0] == 6'h3f)
    else $error("cell drive not thermometer");
  a_slip_gate: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // R9
    !slip_en |-> ##2 CELL_EN_O == 7'h0)
    else $error("cells driven while slip off");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_wide_cycle: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    $rose(st_ff.wide) ##[1:1000] $fell(st_ff.wide));
  c_fraction_numerator_carry: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    pfd_tick && fraction_numerator_carry(acc_sum, modv));
  c_slip_on: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    slip_en && cells != 3'h0);
  c_status_read: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    RE_I && ADDR_I == sflc_pkg::OFS_STATUS);
endmodule : sflc_top

`default_nettype wire

// [verification/sflc_top_tb_top.sv]
// Self-checking bench for the fast-lock synthesizer control.
// Assumes a 40 MHz clock and a reference at a quarter of it.
`default_nettype none

`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module sflc_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, arst_n, we, re, kick, kup, pass;
  logic [4:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] kn;
  logic [1:0] rcnt;
  logic warn, passed, tup, pfd_clk, pfd_tick, boost, sw, src;
  logic [16:0] ndiv;
  logic [6:0] cells;
  int fail_count = 0;
  int total_checks = 0;

  // --------------------------------------------------------------
  // Clock, reset, reference
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {we, re, kick, kup, pass, addr, wdata, kn, rcnt} = '0;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
  end
  // Reference at 10 MHz, doubled at most to 20 MHz
  always @(posedge clk) begin
    rcnt <= rcnt + 2'h1;
  end

  sflc_top dut (.CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we),
    .RE_I(re), .RDATA_O(rdata), .REF_I(rcnt[1]), .SLIP_WARN_I(warn),
    .FREQ_PASSED_I(passed), .TUNE_UP_I(tup), .PFD_CLK_O(pfd_clk), .PFD_TICK_O(pfd_tick),
    .N_DIV_O(ndiv), .CP_BOOST_O(boost), .MULTIPLEXED_OUTPUT_PIN_O(sw), .CELL_EN_O(cells),
    .CELL_SRC_O(src));
  sflc_vco_model vco (.clk_i(clk), .arst_n_i(arst_n), .kick_i(kick), .up_i(kup),
    .n_i(kn), .pass_i(pass), .warn_o(warn), .passed_o(passed), .up_o(tup));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  function automatic logic [31:0] mc(input logic [11:0] m, input logic [4:0] r,
                                     input logic d, input logic h, input logic s);
    mc = 32'h0;
    mc[14:3] = m;
    mc[19:15] = r;
    mc[sflc_pkg::DBL_BIT] = d;
    mc[sflc_pkg::HALF_BIT] = h;
    mc[sflc_pkg::SLIP_EN_BIT] = s;
  endfunction : mc

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 q = rdata;
  endtask : rd

  task automatic wait_tick();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (pfd_tick !== 1'b1 && k < 300);
  endtask : wait_tick

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic regs_case();
    logic [31:0] q;
    rd(sflc_pkg::OFS_MOD_CNT, q);
    `CHK("mod reset", 32'h0, q)
    wr(5'h04, 32'hffff_ffff);
    rd(5'h04, q);
    `CHK("unmapped", 32'h0, q)
    wr(sflc_pkg::OFS_FUNCTION, 32'h40);
    wr(sflc_pkg::OFS_MOD_CNT, mc(12'hfff, 5'h1f, 1'b1, 1'b0, 1'b0));
    rd(sflc_pkg::OFS_MOD_CNT, q);
    `CHK("mod max", mc(12'hfff, 5'h1f, 1'b1, 1'b0, 1'b0), q)
  endtask : regs_case

  task automatic ref_case(input logic [4:0] r, input logic d, input logic h, input int per);
    int n;
    int hi;
    wr(sflc_pkg::OFS_MOD_CNT, mc(12'h5, r, d, h, 1'b0));
    wait_tick();
    wait_tick();
    n = 0;
    hi = 0;
    do begin
      @(posedge clk);
      #1 n++;
      hi += pfd_clk;
    end while (pfd_tick !== 1'b1 && n < 200);
    `CHK("pfd period", per, n)
    if (h) `CHK("pfd high", per / 2, hi)
  endtask : ref_case

  task automatic fraction_numerator_case();
    int s;
    wr(sflc_pkg::OFS_MOD_CNT, mc(12'h5, 5'h1, 1'b0, 1'b0, 1'b0));
    wr(sflc_pkg::OFS_CLK_DIV, 32'h0);
    wr(sflc_pkg::OFS_FRACTION_NUMERATOR_INT, {1'b0, 16'd100, 12'h2, 3'h0});
    s = 0;
    repeat (5) begin
      wait_tick();
      @(posedge clk);
      #1 s += ndiv;
    end
    `CHK("n sum", 502, s)
  endtask : fraction_numerator_case

  task automatic wb_case(input logic [1:0] m, input logic [11:0] v, input logic d, input int e);
    int t;
    int k;
    wr(sflc_pkg::OFS_MOD_CNT, mc(12'h5, 5'h1, d, 1'b0, 1'b0));
    wr(sflc_pkg::OFS_CLK_DIV, {11'h0, m, v, 7'h0});
    wr(sflc_pkg::OFS_FRACTION_NUMERATOR_INT, {1'b0, 16'd100, 12'h2, 3'h0});
    #1 `CHK("boost on", (e != 0), boost)
    `CHK("switch on", (e != 0), sw)
    t = 0;
    k = 0;
    while (boost === 1'b1 && k < 20000) begin
      t += pfd_tick;
      @(posedge clk);
      #1 k++;
    end
    `CHK("wideband ticks", e, t)
    `CHK("switch off", 1'b0, sw)
  endtask : wb_case

  task automatic slip_case(input logic s, input logic u, input logic [3:0] n, input int c);
    logic [31:0] q;
    wr(sflc_pkg::OFS_MOD_CNT, mc(12'h5, 5'h1, 1'b0, 1'b1, s));
    @(posedge clk);
    kick <= 1'b1;
    kup <= u;
    kn <= n;
    @(posedge clk);
    kick <= 1'b0;
    repeat (24) @(posedge clk);
    #1 `CHK("cells up", 7'h7f >> (7 - c), cells)
    if (c != 0) `CHK("cell dir", u, src)
    rd(sflc_pkg::OFS_STATUS, q);
    `CHK("status", {2'h2, u && c != 0, 3'(c)}, q[5:0])
    wait_tick();
    @(posedge clk);
    pass <= 1'b1;
    @(posedge clk);
    pass <= 1'b0;
    for (int k = c - 1; k >= 0; k--) begin
      wait_tick();
      repeat (2) @(posedge clk);
      #1 `CHK("cells down", 7'h7f >> (7 - k), cells)
    end
  endtask : slip_case

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    @(posedge arst_n);
    regs_case();
    ref_case(5'h1, 1'b0, 1'b0, 4);
    ref_case(5'h3, 1'b1, 1'b0, 6);
    ref_case(5'h3, 1'b0, 1'b1, 24);
    ref_case(5'h0, 1'b0, 1'b0, 128);
    fraction_numerator_case();
    wb_case(2'h1, 12'h3, 1'b0, 3);
    wb_case(2'h0, 12'h3, 1'b0, 0);
    wb_case(2'h1, 12'hfff, 1'b1, 4095);
    slip_case(1'b1, 1'b1, 4'h9, 7);
    slip_case(1'b1, 1'b0, 4'h3, 3);
    slip_case(1'b0, 1'b1, 4'h3, 0);
    close_out();
  end

  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule : sflc_top_tb_top

`default_nettype wire

// [verification/sflc_vco_model.sv]
// Partner model: oscillator and loop filter, seen as phase detector flags.
// Assumes it shares the clock and reset of the control block.
`default_nettype none

module sflc_vco_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Bench commands
  input wire logic kick_i,
  input wire logic up_i,
  input wire logic [3:0] n_i,
  input wire logic pass_i,
  // Detector flags
  output logic warn_o,
  output logic passed_o,
  output logic up_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] left_ff;

  // Growing phase error: one slip warning every other cycle until spent
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      left_ff <= 4'h0;
      warn_o <= 1'b0;
      passed_o <= 1'b0;
      up_o <= 1'b0;
    end else begin
      if (kick_i) begin
        left_ff <= n_i;
        up_o <= up_i;
      end else if (left_ff != 4'h0 && !warn_o) begin
        left_ff <= left_ff - 4'h1;
      end
      warn_o <= !kick_i && left_ff != 4'h0 && !warn_o;
      passed_o <= pass_i; // Tuning has crossed the target
    end
  end
endmodule : sflc_vco_model

`default_nettype wire
